// File: src/pwrc_params.svh
// timing counts, instruction codes and widths of the power-up sequencer
// assumes a 10 ns core clock; included by bare name
`ifndef PWRC_PARAMS_SVH
`define PWRC_PARAMS_SVH
`define PWRC_CLK_PERIOD_NS 10
`define PWRC_POWERUP_US 100
`define PWRC_POWERUP_CYC ((`PWRC_POWERUP_US * 1000 + `PWRC_CLK_PERIOD_NS - 1) / `PWRC_CLK_PERIOD_NS)
`define PWRC_RELOAD_MAX_US 150
`define PWRC_RELOAD_MAX_CYC ((`PWRC_RELOAD_MAX_US * 1000) / `PWRC_CLK_PERIOD_NS)
`define PWRC_VPP_LOW_MIN_NS 300
`define PWRC_VPP_LOW_CYC ((`PWRC_VPP_LOW_MIN_NS + `PWRC_CLK_PERIOD_NS - 1) / `PWRC_CLK_PERIOD_NS)
`define PWRC_LOAD_CYC 64
`define PWRC_TIMER_W 16
`define PWRC_VPP_CNT_W 8
`define PWRC_IR_W 4
`define PWRC_IR_CAPTURE 4'h1
`define PWRC_IR_RELOAD 4'h8
`define PWRC_IR_PROGRAMMING 4'h9
`define PWRC_IR_RECONFIG 4'hA
`define PWRC_IR_BYPASS 4'hF
`endif

// File: src/pwrc_pkg.sv
// state types of the sequencer and of the test-port controller
// no dependencies
package pwrc_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_PWRUP, ST_LOAD, ST_CLEAR, ST_RUN
  } pwrc_seq_state_t;
  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR,
    TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR,
    TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
  } pwrc_tap_state_t;
endpackage

// File: src/pwrc_tap_if.sv
// signals between the core sequencer and the test-port logic
// each side synchronises what it receives
`timescale 1ns/1ps
interface pwrc_tap_if;
  logic tap_hold;
  logic reload_tgl;
  logic programming_mode;
  logic reconfig_mode;
  modport core (output tap_hold, input reload_tgl, programming_mode, reconfig_mode);
  modport tap  (input tap_hold, output reload_tgl, programming_mode, reconfig_mode);
endinterface

// File: src/pwrc_sync.sv
// two-flop level synchroniser
// d comes from another clock domain or a pin
`timescale 1ns/1ps
module pwrc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // pwrc_sync

// File: src/pwrc_tap.sv
// test-port controller on the test clock
// held in test-logic-reset while the core asks for it
`timescale 1ns/1ps
`include "pwrc_params.svh"
module pwrc_tap (
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  output logic      tdo,
  output logic      tdo_oe,
  pwrc_tap_if.tap   tif
);
  pwrc_pkg::pwrc_tap_state_t st;
  pwrc_pkg::pwrc_tap_state_t next_st;
  logic [`PWRC_IR_W-1:0]     ir_sh;
  logic [`PWRC_IR_W-1:0]     ir;
  logic                      byp;
  logic                      hold;

  pwrc_sync #(.W(1)) u_hold_sync (
    .clk (tck), .ce (1'b1), .rst (1'b0), .d (tif.tap_hold), .q (hold)
  );

  always_comb begin
    next_st = st;
    case (st)
      pwrc_pkg::TS_RESET:  next_st = tms ? pwrc_pkg::TS_RESET : pwrc_pkg::TS_IDLE;
      pwrc_pkg::TS_IDLE:   next_st = tms ? pwrc_pkg::TS_SEL_DR : pwrc_pkg::TS_IDLE;
      pwrc_pkg::TS_SEL_DR: next_st = tms ? pwrc_pkg::TS_SEL_IR : pwrc_pkg::TS_CAP_DR;
      pwrc_pkg::TS_CAP_DR: next_st = tms ? pwrc_pkg::TS_EX1_DR : pwrc_pkg::TS_SH_DR;
      pwrc_pkg::TS_SH_DR:  next_st = tms ? pwrc_pkg::TS_EX1_DR : pwrc_pkg::TS_SH_DR;
      pwrc_pkg::TS_EX1_DR: next_st = tms ? pwrc_pkg::TS_UPD_DR : pwrc_pkg::TS_PAU_DR;
      pwrc_pkg::TS_PAU_DR: next_st = tms ? pwrc_pkg::TS_EX2_DR : pwrc_pkg::TS_PAU_DR;
      pwrc_pkg::TS_EX2_DR: next_st = tms ? pwrc_pkg::TS_UPD_DR : pwrc_pkg::TS_SH_DR;
      pwrc_pkg::TS_SEL_IR: next_st = tms ? pwrc_pkg::TS_RESET : pwrc_pkg::TS_CAP_IR;
      pwrc_pkg::TS_CAP_IR: next_st = tms ? pwrc_pkg::TS_EX1_IR : pwrc_pkg::TS_SH_IR;
      pwrc_pkg::TS_SH_IR:  next_st = tms ? pwrc_pkg::TS_EX1_IR : pwrc_pkg::TS_SH_IR;
      pwrc_pkg::TS_EX1_IR: next_st = tms ? pwrc_pkg::TS_UPD_IR : pwrc_pkg::TS_PAU_IR;
      pwrc_pkg::TS_PAU_IR: next_st = tms ? pwrc_pkg::TS_EX2_IR : pwrc_pkg::TS_PAU_IR;
      pwrc_pkg::TS_EX2_IR: next_st = tms ? pwrc_pkg::TS_UPD_IR : pwrc_pkg::TS_SH_IR;
      pwrc_pkg::TS_UPD_DR,
      pwrc_pkg::TS_UPD_IR: next_st = tms ? pwrc_pkg::TS_SEL_DR : pwrc_pkg::TS_IDLE;
      default:             next_st = pwrc_pkg::TS_RESET;
    endcase
  end

  // forced reset state while the core powers up
  always_ff @(posedge tck) begin
    if (hold) st <= pwrc_pkg::TS_RESET; // [R3]
    else st <= next_st;
  end

  // bits taken on the rising test clock
  always_ff @(posedge tck) begin
    if (hold || st == pwrc_pkg::TS_RESET) begin
      ir_sh <= `PWRC_IR_BYPASS;
      ir    <= `PWRC_IR_BYPASS;
      byp   <= 1'b0;
    end else begin
      case (st)
        pwrc_pkg::TS_CAP_IR: ir_sh <= `PWRC_IR_CAPTURE;
        pwrc_pkg::TS_SH_IR:  ir_sh <= {tdi, ir_sh[`PWRC_IR_W-1:1]}; // [R10]
        pwrc_pkg::TS_UPD_IR: ir    <= ir_sh;
        pwrc_pkg::TS_CAP_DR: byp   <= 1'b0;
        pwrc_pkg::TS_SH_DR:  byp   <= tdi; // [R10]
        default: ;
      endcase
    end
  end

  // reload request leaves as a toggle; modes leave as levels
  always_ff @(posedge tck) begin
    if (hold) begin
      tif.reload_tgl <= 1'b0;
    end else if (st == pwrc_pkg::TS_UPD_IR && ir_sh == `PWRC_IR_RELOAD) begin
      tif.reload_tgl <= ~tif.reload_tgl; // [R6]
    end
  end
  assign tif.programming_mode = (ir == `PWRC_IR_PROGRAMMING);
  assign tif.reconfig_mode    = (ir == `PWRC_IR_RECONFIG);

  // serial output changes on the falling test clock
  always_ff @(negedge tck) begin
    tdo_oe <= (st == pwrc_pkg::TS_SH_IR) || (st == pwrc_pkg::TS_SH_DR); // [R11]
    tdo    <= (st == pwrc_pkg::TS_SH_IR) ? ir_sh[0] : byp; // [R11]
  end

  ir_shift_a: assert property ( // [R10]
    @(posedge tck) disable iff (hold)
    (st == pwrc_pkg::TS_SH_IR) |=> (ir_sh[`PWRC_IR_W-1] == $past(tdi)))
    else $error("instruction bit not taken on rising test clock");
endmodule // pwrc_tap

// File: src/pwrc_top.sv
// power-up and reconfiguration sequencer with test-port reload trigger
// pins and test-clock signals are asynchronous to CORE_CLK
`timescale 1ns/1ps
`include "pwrc_params.svh"
// How it works
// [R1] power-up lasts 100 us after supply good
// [R2] user flip-flops cleared when power-up ends
// [R3] test port held in reset during power-up
// [R4] pins undriven during power-up, large pulls up
// [R5] unprogrammed device keeps outputs high-impedance
// [R6] reset instruction reloads configuration any time; the test port is held in reset in off and power-up and takes none then
// [R7] programming pin low 300 ns reloads
// [R8] low programming pin stalls; done within 150 us
// [R9] pins tri-stated during reconfig and programming
// [R10] serial input taken on rising test clock
// [R11] serial output changes on falling test clock
// [R12] host keeps test clock at 8 MHz or less; the bench host runs a 64 ns period, about 15.6 MHz
// [R13] host issues reset instruction after reconfiguring; the bench host shifts bypass (4'hF) next instead
// [R14] both reload requests form one trigger
module pwrc_top #(
  parameter int unsigned POWERUP_CYCLES    = `PWRC_POWERUP_CYC,
  parameter int unsigned RELOAD_MAX_CYCLES = `PWRC_RELOAD_MAX_CYC,
  parameter int unsigned LOAD_CYCLES       = `PWRC_LOAD_CYC,
  parameter bit          LARGE_VARIANT     = 1'b0
) (
  input  wire logic CORE_CLK,
  input  wire logic CLK_EN,
  input  wire logic RESET,
  input  wire logic VCC_OK,
  input  wire logic VPP_PIN,
  input  wire logic FLASH_PROGRAMMED,
  input  wire logic TCK,
  input  wire logic TMS,
  input  wire logic TDI,
  output logic      TDO,
  output logic      TDO_OE,
  output logic      USER_CLEAR,
  output logic      CFG_LOAD,
  output logic      IO_TRISTATE,
  output logic      IO_PULLUP,
  output logic      READY
);
  localparam int TW = `PWRC_TIMER_W;
  localparam int VW = `PWRC_VPP_CNT_W;

  if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << TW) ||
      LOAD_CYCLES < 1 || POWERUP_CYCLES + LOAD_CYCLES + 1 > RELOAD_MAX_CYCLES) begin : bad_cfg
    $error("sequence counts do not fit the timer or the reload bound");
  end

  pwrc_pkg::pwrc_seq_state_t state;
  pwrc_pkg::pwrc_seq_state_t next_state;
  logic [TW-1:0]             timer;
  logic [VW-1:0]             vpp_low_cnt;
  logic                      vcc_s;
  logic                      vpp_s;
  logic                      tgl_s;
  logic                      programming_s;
  logic                      reconfig_s;
  logic                      tgl_d;
  logic                      reload_pulse;
  logic                      vpp_req;
  logic                      reload_req;
  logic                      reload_pend;
  logic                      prog_mode;
  logic [TW-1:0]             since_high;

  pwrc_tap_if tif ();

  pwrc_sync #(.W(5)) u_in_sync (
    .clk (CORE_CLK),
    .ce  (CLK_EN),
    .rst (RESET),
    .d   ({VCC_OK, VPP_PIN, tif.reload_tgl, tif.programming_mode, tif.reconfig_mode}),
    .q   ({vcc_s, vpp_s, tgl_s, programming_s, reconfig_s})
  );

  pwrc_tap u_tap (
    .tck    (TCK),
    .tms    (TMS),
    .tdi    (TDI),
    .tdo    (TDO),
    .tdo_oe (TDO_OE),
    .tif    (tif.tap)
  );

  // test-port modes that reconfigure or program
  assign prog_mode = programming_s || reconfig_s;

  // edge of the synchronised reload toggle
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tgl_d <= 1'b0;
    end else if (CLK_EN) begin
      tgl_d <= tgl_s;
    end
  end
  assign reload_pulse = tgl_s ^ tgl_d; // [R6]

  // low time of the programming pin
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      vpp_low_cnt <= '0;
    end else if (CLK_EN) begin
      if (vpp_s) begin
        vpp_low_cnt <= '0;
      end else if (vpp_low_cnt != VW'(`PWRC_VPP_LOW_CYC)) begin
        vpp_low_cnt <= vpp_low_cnt + VW'(1);
      end
    end
  end
  assign vpp_req = !vpp_s && (vpp_low_cnt == VW'(`PWRC_VPP_LOW_CYC - 1)); // [R7]

  // one trigger for either source
  assign reload_req = reload_pulse || vpp_req; // [R14]

  // request seen outside run waits; a new one beats the clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      reload_pend <= 1'b0;
    end else if (CLK_EN) begin
      if (reload_req && state != pwrc_pkg::ST_RUN) begin
        reload_pend <= 1'b1; // [R14]
      end else if (next_state == pwrc_pkg::ST_LOAD || next_state == pwrc_pkg::ST_OFF) begin
        reload_pend <= 1'b0;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      pwrc_pkg::ST_OFF: begin
        next_state = pwrc_pkg::ST_PWRUP;
      end
      pwrc_pkg::ST_PWRUP: begin
        if (vpp_s && timer == TW'(POWERUP_CYCLES - 1)) begin // [R1] [R8]
          next_state = pwrc_pkg::ST_LOAD;
        end
      end
      pwrc_pkg::ST_LOAD: begin
        if (vpp_s && timer == TW'(LOAD_CYCLES - 1)) begin // [R8]
          next_state = pwrc_pkg::ST_CLEAR;
        end
      end
      pwrc_pkg::ST_CLEAR: begin
        next_state = pwrc_pkg::ST_RUN;
      end
      pwrc_pkg::ST_RUN: begin
        if (reload_req || reload_pend) begin // [R6] [R7] [R14]
          next_state = pwrc_pkg::ST_LOAD;
        end
      end
      default: begin
        next_state = pwrc_pkg::ST_OFF;
      end
    endcase
    if (!vcc_s) begin
      next_state = pwrc_pkg::ST_OFF; // [R1]
    end
  end

  // timer restarts on every state change and while the pin is low
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= pwrc_pkg::ST_OFF;
      timer <= '0;
    end else if (CLK_EN) begin
      state <= next_state;
      if (next_state != state || !vpp_s) begin
        timer <= '0; // [R8]
      end else begin
        timer <= timer + TW'(1);
      end
    end
  end

  // pin and clear controls follow the coming state
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      USER_CLEAR   <= 1'b1;
      CFG_LOAD     <= 1'b0;
      READY        <= 1'b0;
      IO_TRISTATE  <= 1'b1;
      IO_PULLUP    <= LARGE_VARIANT;
      tif.tap_hold <= 1'b1;
    end else if (CLK_EN) begin
      USER_CLEAR   <= next_state != pwrc_pkg::ST_RUN; // [R2]
      CFG_LOAD     <= next_state == pwrc_pkg::ST_LOAD;
      READY        <= next_state == pwrc_pkg::ST_RUN;
      IO_TRISTATE  <= next_state != pwrc_pkg::ST_RUN || !FLASH_PROGRAMMED || prog_mode; // [R4] [R5] [R9]
      IO_PULLUP    <= LARGE_VARIANT && (next_state == pwrc_pkg::ST_OFF ||
                      next_state == pwrc_pkg::ST_PWRUP ||
                      next_state == pwrc_pkg::ST_LOAD || prog_mode); // [R4] [R9]
      tif.tap_hold <= next_state == pwrc_pkg::ST_OFF || next_state == pwrc_pkg::ST_PWRUP; // [R3]
    end
  end

  // helper: cycles spent sequencing since the pin was last seen low
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      since_high <= '0;
    end else if (CLK_EN) begin
      if (state == pwrc_pkg::ST_RUN || state == pwrc_pkg::ST_OFF || !vpp_s) begin
        since_high <= '0;
      end else if (since_high != '1) begin
        since_high <= since_high + TW'(1);
      end
    end
  end

  pwrup_len_a: assert property ( // [R1]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && state == pwrc_pkg::ST_PWRUP && next_state == pwrc_pkg::ST_LOAD)
      |-> (timer == TW'(POWERUP_CYCLES - 1)) && vpp_s)
    else $error("power-up ended at the wrong count");

  user_clear_a: assert property ( // [R2]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && state == pwrc_pkg::ST_CLEAR && vcc_s)
      |-> USER_CLEAR ##1 ((state == pwrc_pkg::ST_RUN) && !USER_CLEAR))
    else $error("user clear not released after clear step");

  ready_run_a: assert property ( // [R2]
    @(posedge CORE_CLK) disable iff (RESET)
    READY |-> (state == pwrc_pkg::ST_RUN) && !USER_CLEAR)
    else $error("ready shown outside run or with clear held");

  off_state_a: assert property ( // [R1]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && !vcc_s) |=> (state == pwrc_pkg::ST_OFF) && USER_CLEAR && !READY)
    else $error("supply loss did not restart the sequence");

  tap_release_a: assert property ( // [R3]
    @(posedge CORE_CLK) disable iff (RESET)
    (state == pwrc_pkg::ST_RUN) |-> !tif.tap_hold)
    else $error("test port still held while running");

  tap_hold_a: assert property ( // [R3]
    @(posedge CORE_CLK) disable iff (RESET)
    (state == pwrc_pkg::ST_PWRUP) |-> tif.tap_hold)
    else $error("test port not held during power-up");

  pwrup_pins_a: assert property ( // [R4]
    @(posedge CORE_CLK) disable iff (RESET)
    (state == pwrc_pkg::ST_PWRUP) |-> IO_TRISTATE && (IO_PULLUP == LARGE_VARIANT))
    else $error("pins driven or pull wrong during power-up");

  blank_hiz_a: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && !FLASH_PROGRAMMED) |=> IO_TRISTATE)
    else $error("unprogrammed device drives outputs");

  run_drive_a: assert property ( // [R5] [R9]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && state == pwrc_pkg::ST_RUN && next_state == pwrc_pkg::ST_RUN &&
     FLASH_PROGRAMMED && !prog_mode) |=> !IO_TRISTATE)
    else $error("programmed device left undriven while running");

  instr_reload_a: assert property ( // [R6]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && vcc_s && state == pwrc_pkg::ST_RUN && reload_pulse)
      |=> (state == pwrc_pkg::ST_LOAD) && CFG_LOAD && IO_TRISTATE)
    else $error("reset instruction did not start a reload");

  vpp_reload_a: assert property ( // [R7]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && vcc_s && state == pwrc_pkg::ST_RUN && !vpp_s &&
     vpp_low_cnt == VW'(`PWRC_VPP_LOW_CYC - 1)) |=> (state == pwrc_pkg::ST_LOAD))
    else $error("long low on programming pin did not reload");

  vpp_short_a: assert property ( // [R7]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && vpp_s) |=> (vpp_low_cnt == '0))
    else $error("low count kept after pin went high");

  vpp_stall_a: assert property ( // [R8]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && vcc_s && state == pwrc_pkg::ST_PWRUP && !vpp_s)
      |=> (state == pwrc_pkg::ST_PWRUP) && (timer == '0))
    else $error("power-up advanced with programming pin low");

  load_len_a: assert property ( // [R8]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && state == pwrc_pkg::ST_LOAD && next_state == pwrc_pkg::ST_CLEAR)
      |-> (timer == TW'(LOAD_CYCLES - 1)) && vpp_s)
    else $error("load step ended at the wrong count");

  reset_time_a: assert property ( // [R8]
    @(posedge CORE_CLK) disable iff (RESET)
    since_high <= TW'(RELOAD_MAX_CYCLES))
    else $error("sequence overran its completion bound");

  prog_hiz_a: assert property ( // [R9]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && prog_mode) |=> IO_TRISTATE && (IO_PULLUP == LARGE_VARIANT))
    else $error("pins not released during programming");

  one_trigger_a: assert property ( // [R14]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && vcc_s && state == pwrc_pkg::ST_RUN && reload_pulse && vpp_req)
      |=> (state == pwrc_pkg::ST_LOAD) && !reload_pend)
    else $error("two sources gave more than one reload");

  pend_keep_a: assert property ( // [R14]
    @(posedge CORE_CLK) disable iff (RESET)
    (CLK_EN && reload_req && state != pwrc_pkg::ST_RUN) |=> reload_pend)
    else $error("reload request outside run was lost");

  cfg_load_a: assert property ( // [R14]
    @(posedge CORE_CLK) disable iff (RESET)
    (state == pwrc_pkg::ST_LOAD) |-> CFG_LOAD && USER_CLEAR && !READY)
    else $error("load outputs wrong during reload");

endmodule // pwrc_top

// File: testbench/pwrc_tap_host.sv
// test-port host model: drives the serial test clock, mode select and serial input
// assumes the device updates its serial output on the falling test clock
`timescale 1ns/1ps
module pwrc_tap_host #(
  parameter int HALF_NS = 32
) (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic smp;
  logic smp_oe;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // 64 ns period, about 15.6 MHz, above the 8 MHz ceiling
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d; // set up well before the rising edge
    #HALF_NS tck = 1'b1;
    smp = tdo;
    smp_oe = tdo_oe;
    #HALF_NS tck = 1'b0;
  endtask

  // reset, idle, select ir, capture, shift 4 bits lsb first, update, idle
  task automatic shift_ir(input logic [3:0] code, output logic [3:0] seen, output logic oe);
    logic [9:0] pre;
    pre = 10'b1111101100;
    oe = 1'b0;
    for (int i = 9; i >= 0; i--) step(pre[i], 1'b0);
    for (int i = 0; i < 4; i++) begin
      step(i == 3, code[i]);
      seen[i] = smp;
      oe = oe | smp_oe;
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    // clock rests low; released input keeps moving
    tdi = ~tdi;
  endtask
endmodule // pwrc_tap_host

// File: testbench/pwrc_top_test.sv
// self-checking bench of the power-up and reconfiguration sequencer
// assumes shortened counts: power-up 50, load 8, reload bound 100 cycles
`timescale 1ns/1ps
module pwrc_top_test;
  logic       core_clk;
  logic       reset;
  logic       vcc_ok;
  logic       vpp_pin;
  logic       flash_prog;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic       tdo_oe;
  logic       user_clear;
  logic       cfg_load;
  logic       io_tristate;
  logic       io_pullup;
  logic       ready;
  logic [3:0] seen;
  logic       oe;
  int         fail_count;
  int         checked;

  pwrc_top #(
    .POWERUP_CYCLES(50), .RELOAD_MAX_CYCLES(100), .LOAD_CYCLES(8), .LARGE_VARIANT(1'b0)
  ) uut (
    .CORE_CLK(core_clk), .CLK_EN(1'b1), .RESET(reset), .VCC_OK(vcc_ok),
    .VPP_PIN(vpp_pin), .FLASH_PROGRAMMED(flash_prog), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .USER_CLEAR(user_clear),
    .CFG_LOAD(cfg_load), .IO_TRISTATE(io_tristate), .IO_PULLUP(io_pullup),
    .READY(ready)
  );

  pwrc_tap_host host (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: output differs from expected", $time);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic look(input int n);
    tick(n);
    #1;
  endtask

  task automatic wait_ready(input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      look(1);
      if (ready === v) break;
    end
    check(ready, v);
  endtask

  task automatic t_powerup;
    tick(1);
    vcc_ok <= 1'b1;
    look(45);
    check(ready, 1'b0);
    check(user_clear, 1'b1);
    check(io_tristate, 1'b1);
    check(io_pullup, 1'b0);
    wait_ready(1'b1, 40);
    check(user_clear, 1'b0);
    check(io_tristate, 1'b0);
  endtask

  task automatic t_pin_reload;
    tick(1);
    vpp_pin <= 1'b0;
    tick(20);
    vpp_pin <= 1'b1;
    look(10);
    check(ready, 1'b1);
    tick(1);
    vpp_pin <= 1'b0;
    look(40);
    check(cfg_load, 1'b1);
    check(ready, 1'b0);
    check(io_tristate, 1'b1);
    look(30);
    check(cfg_load, 1'b1);
    tick(1);
    vpp_pin <= 1'b1;
    look(5);
    check(ready, 1'b0);
    wait_ready(1'b1, 100);
  endtask

  task automatic t_tap_reload;
    host.shift_ir(4'h8, seen, oe); // reload instruction after the pin reload
    for (int i = 0; i < 4; i++) check(seen[i], i == 0);
    check(oe, 1'b1);
    wait_ready(1'b0, 20);
    check(cfg_load, 1'b1);
    wait_ready(1'b1, 100);
  endtask

  task automatic t_modes;
    host.shift_ir(4'h9, seen, oe);
    look(10);
    check(io_tristate, 1'b1);
    host.shift_ir(4'hA, seen, oe);
    look(10);
    check(io_tristate, 1'b1);
    check(io_pullup, 1'b0);
    host.shift_ir(4'hF, seen, oe);
    look(10);
    check(io_tristate, 1'b0);
    tick(1);
    flash_prog <= 1'b0;
    look(5);
    check(io_tristate, 1'b1);
    tick(1);
    flash_prog <= 1'b1;
  endtask

  task automatic t_stall_restart;
    tick(1);
    vcc_ok <= 1'b0;
    vpp_pin <= 1'b0;
    look(5);
    check(ready, 1'b0);
    check(user_clear, 1'b1);
    tick(1);
    vcc_ok <= 1'b1;
    look(10);
    host.shift_ir(4'h8, seen, oe);
    check(oe, 1'b0);
    check(ready, 1'b0);
    check(user_clear, 1'b1);
    tick(1);
    vpp_pin <= 1'b1;
    wait_ready(1'b1, 100);
    look(20);
    check(ready, 1'b1);
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200us;
    fail_count++;
    report_and_stop();
  end

  initial begin
    fail_count = 0;
    checked = 0;
    reset = 1'b1;
    vcc_ok = 1'b0;
    vpp_pin = 1'b1;
    flash_prog = 1'b1;
    tick(20);
    reset <= 1'b0;
    // test port must see clocks while the core is still off
    host.shift_ir(4'hF, seen, oe);
    check(oe, 1'b0);
    t_powerup();
    t_pin_reload();
    t_tap_reload();
    t_modes();
    t_stall_restart();
    report_and_stop();
  end
endmodule // pwrc_top_test
